// ==== src/msps_pkg.sv ====
// shared constants and types for the multislope phase sequencer and its host
package msps_pkg;
  // sequence phases of one conversion
  typedef enum logic [2:0] {
    PH_ZI_HOLD,
    PH_ZI_PRE,
    PH_INTEG,
    PH_DEINT,
    PH_REST,
    PH_RESIDUE_GAIN,
    PH_ZI_END
  } msps_phase_t;

  // conversion clock timing; phase lengths in conversion clocks
  localparam int CONV_CLK_HZ = 32768;
  localparam int SYS_CLK_HZ = 250000000;
  localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
  localparam int CONV_COUNTS = 2048;
  localparam logic [10:0] PRE_ZI_60_CLKS = 11'h06F;
  localparam logic [10:0] PRE_ZI_50_CLKS = 11'h001;
  localparam logic [10:0] INTEG_60_CLKS = 11'h221;
  localparam logic [10:0] INTEG_50_CLKS = 11'h28F;
  localparam logic [10:0] END_ZI_CLKS = 11'h014;
  localparam logic [10:0] DEINT_MAX_CLKS = 11'h150;
  localparam logic [10:0] RESIDUE_CLKS = 11'h008;
  localparam logic [1:0] LAST_DEINT = 2'h3;
  localparam int RESIDUE_GAIN = 8;
  localparam logic [18:0] WEIGHT_FIRST = 19'h00200;

  // command byte fields
  localparam int CMD_REG1_BIT = 0;
  localparam int CMD_START_BIT = 1;
  localparam int CMD_MODE50_BIT = 2;
  localparam int CMD_SEL_LOW_BIT = 3;
  localparam int CMD_SEL_HIGH_BIT = 4;

  // output register select {output_select_high, output_select_low}
  localparam logic [1:0] SEL_LOW_BYTE = 2'h0;
  localparam logic [1:0] SEL_HIGH_BYTE = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_RESET = SEL_STATUS;

  // status byte fields
  localparam int ST_COLL_BIT = 7;
  localparam int ST_EOC_BIT = 6;
  localparam int ST_INT_BIT = 5;

  // host timing
  localparam int IDLE_LIMIT_S = 2;
  localparam int IDLE_LIMIT_CLKS = IDLE_LIMIT_S * SYS_CLK_HZ;
  localparam int SCLK_HALF_CLKS = 8;
endpackage

// ==== src/msps_if.sv ====
// serial link between the converter sequencer and its host
`timescale 1ns/1ps
interface msps_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout;
  logic eoc;
  modport device (input cs_n, input sclk, input din, output dout, output eoc);
  modport host (output cs_n, output sclk, output din, input dout, input eoc);
endinterface

// ==== src/msps_device.sv ====
// converter-side phase sequencer with serial command and result port
`timescale 1ns/1ps
// Summary of operation
// - deintegrate one more conversion clock after crossing
// - residue gain phase follows first deintegrate
// - second deintegrate clock weighs one eighth
// - gain then deintegrate after second, third
// - zero-integrate at start and end
// - hold in zero-integrate until start command
// - 60Hz start adds 111 zero-integrate clocks
// - 50Hz start adds one zero-integrate clock
// - twenty zero-integrate clocks end each conversion
// - 32768 Hz clock gives sixteen conversions/second
// - 50Hz integrate period longer than 60Hz
// - host flags result stale after two-second idle
// - host uses 50Hz above sixteen conversions/second
// - host keeps serial idle while converting before reads; start is sent without waiting
// - transfer shifts command in, selected register out
// - host writes before reads, three transfers
// - integrate 545 counts 60Hz, 655 50Hz
// - result steps 512, 64, 8, 1 signed
// - 2048-count cycle, done flag set/cleared
// - select bits choose low or high byte
module msps_device #(
  parameter int CONV_DIV_P = msps_pkg::CONV_DIV
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  msps_if.device LINK,
  input wire logic COMP_ZERO_IN,
  input wire logic COMP_POS_IN,
  output msps_pkg::msps_phase_t PHASE_OUT,
  output logic [1:0] DEINT_INDEX_OUT,
  output logic DEINT_NEG_OUT,
  output logic INTEG_OUT,
  output logic [3:0] USER_BITS_OUT,
  output logic [18:0] RESULT_OUT
);
  import msps_pkg::*;

  logic [12:0] div_q;
  logic tick_q;
  msps_phase_t phase_q;
  logic [10:0] ph_cnt_q;
  logic [10:0] seq_q;
  logic [1:0] idx_q;
  logic neg_q;
  logic cross_q;
  logic [18:0] acc_q;
  logic [18:0] result_q;
  logic eoc_q;
  logic int_q;
  logic mode50_q;
  logic start_q;
  logic [1:0] sel_q;
  logic [3:0] user_q;
  logic coll_q;
  logic latch_in_frame_q;
  logic cs_d1_q;
  logic sclk_d1_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic dout_q;
  logic status_read_q;
  logic [18:0] weight;
  logic [7:0] out_byte;
  logic cs_fall;
  logic cs_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic latch_now;

  // conversion clock enable; the count sets the 2048-count cycle rate
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      div_q <= 13'h0000;
      tick_q <= 1'b0;
    end else if (div_q == 13'(CONV_DIV_P - 1)) begin
      div_q <= 13'h0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 13'h0001;
      tick_q <= 1'b0;
    end
  end

  // each gain stage divides the step by eight
  assign weight = WEIGHT_FIRST >> (3 * idx_q);
  assign latch_now = tick_q && phase_q == PH_ZI_END && ph_cnt_q == 11'h001;

  // crossing seen between conversion clocks; acted on at the next edge only
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cross_q <= 1'b0;
    end else if (phase_q != PH_DEINT || tick_q) begin
      cross_q <= 1'b0;
    end else if (COMP_ZERO_IN) begin
      cross_q <= 1'b1;
    end
  end

  // phase sequencer, advanced on conversion clock ticks
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      phase_q <= PH_ZI_HOLD;
      ph_cnt_q <= 11'h000;
      idx_q <= 2'h0;
      neg_q <= 1'b1;
      int_q <= 1'b0;
    end else if (tick_q) begin
      case (phase_q)
        PH_ZI_HOLD: begin
          if (start_q) begin
            phase_q <= PH_ZI_PRE;
            ph_cnt_q <= mode50_q ? PRE_ZI_50_CLKS : PRE_ZI_60_CLKS;
          end
        end
        PH_ZI_PRE: begin
          ph_cnt_q <= ph_cnt_q - 11'h001;
          if (ph_cnt_q == 11'h001) begin
            phase_q <= PH_INTEG;
            int_q <= 1'b1;
            ph_cnt_q <= mode50_q ? INTEG_50_CLKS : INTEG_60_CLKS;
          end
        end
        PH_INTEG: begin
          ph_cnt_q <= ph_cnt_q - 11'h001;
          if (ph_cnt_q == 11'h001) begin
            phase_q <= PH_DEINT;
            int_q <= 1'b0;
            idx_q <= 2'h0;
            neg_q <= !COMP_POS_IN;
            ph_cnt_q <= DEINT_MAX_CLKS;
          end
        end
        PH_DEINT: begin
          ph_cnt_q <= ph_cnt_q - 11'h001;
          // stop on the tick after the crossing, or when the count reaches one
          if (cross_q || ph_cnt_q == 11'h001) begin
            phase_q <= PH_REST;
          end
        end
        PH_REST: begin
          ph_cnt_q <= ph_cnt_q - 11'h001;
          if (ph_cnt_q <= 11'h001) begin
            if (idx_q == LAST_DEINT) begin
              phase_q <= PH_ZI_END;
              ph_cnt_q <= END_ZI_CLKS;
            end else begin
              phase_q <= PH_RESIDUE_GAIN;
              ph_cnt_q <= RESIDUE_CLKS;
            end
          end
        end
        PH_RESIDUE_GAIN: begin
          ph_cnt_q <= ph_cnt_q - 11'h001;
          if (ph_cnt_q == 11'h001) begin
            phase_q <= PH_DEINT;
            idx_q <= idx_q + 2'h1;
            neg_q <= !COMP_POS_IN; // gained residue is inverted, so resample
            ph_cnt_q <= DEINT_MAX_CLKS;
          end
        end
        PH_ZI_END: begin
          ph_cnt_q <= ph_cnt_q - 11'h001;
          if (ph_cnt_q == 11'h001) begin
            phase_q <= PH_ZI_HOLD;
          end
        end
        default: begin
          phase_q <= PH_ZI_HOLD;
        end
      endcase
    end
  end

  // up/down results counter; no clamp at hard overrange
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      acc_q <= 19'h00000;
    end else if (tick_q && phase_q == PH_ZI_HOLD && start_q) begin
      acc_q <= 19'h00000;
    end else if (tick_q && phase_q == PH_DEINT) begin
      acc_q <= neg_q ? acc_q - weight : acc_q + weight;
    end
  end

  // result latch and 2048-count sequence position
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      result_q <= 19'h00000;
      seq_q <= 11'h000;
      eoc_q <= 1'b1;
    end else if (tick_q) begin
      if (latch_now) begin
        result_q <= acc_q;
        seq_q <= 11'h000;
        eoc_q <= 1'b1;
      end else if (phase_q != PH_ZI_HOLD || start_q) begin
        seq_q <= seq_q + 11'h001;
        if (seq_q == 11'h000) begin
          eoc_q <= 1'b0;
        end
      end
    end
  end

  // serial edge detection on the synchronous link pins
  assign cs_fall = cs_d1_q && !LINK.cs_n;
  assign cs_rise = !cs_d1_q && LINK.cs_n;
  assign sclk_rise = !LINK.cs_n && !sclk_d1_q && LINK.sclk;
  assign sclk_fall = !LINK.cs_n && sclk_d1_q && !LINK.sclk;

  // byte returned is the one chosen by the previous command
  always_comb begin
    case (sel_q)
      SEL_LOW_BYTE: out_byte = result_q[10:3];
      SEL_HIGH_BYTE: out_byte = result_q[18:11];
      default: out_byte = {coll_q, eoc_q, int_q, 2'h0, result_q[2:0]};
    endcase
  end

  // shift command in on rising sclk, result out on falling sclk
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cs_d1_q <= 1'b1;
      sclk_d1_q <= 1'b0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      dout_q <= 1'b0;
    end else begin
      cs_d1_q <= LINK.cs_n;
      sclk_d1_q <= LINK.sclk;
      if (cs_fall) begin
        tx_q <= {out_byte[6:0], 1'b0};
        dout_q <= out_byte[7];
      end else if (sclk_fall) begin
        tx_q <= {tx_q[6:0], 1'b0};
        dout_q <= tx_q[7];
      end
      if (sclk_rise) begin
        rx_q <= {rx_q[6:0], LINK.din};
      end
    end
  end

  // command decode at frame end; start is held until the sequencer takes it
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      sel_q <= SEL_RESET;
      start_q <= 1'b0;
      mode50_q <= 1'b0;
      user_q <= 4'h0;
    end else begin
      if (cs_rise) begin
        sel_q <= {rx_q[CMD_SEL_HIGH_BIT], rx_q[CMD_SEL_LOW_BIT]};
        if (rx_q[CMD_REG1_BIT]) begin
          user_q <= rx_q[7:4];
        end else begin
          mode50_q <= rx_q[CMD_MODE50_BIT];
          if (rx_q[CMD_START_BIT]) begin
            start_q <= 1'b1;
          end
        end
      end else if (tick_q && phase_q == PH_ZI_HOLD) begin
        start_q <= 1'b0;
      end
    end
  end

  // collision: result latched inside a frame; set wins over status-read clear
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      latch_in_frame_q <= 1'b0;
      status_read_q <= 1'b0;
      coll_q <= 1'b0;
    end else begin
      if (cs_fall) begin
        status_read_q <= (sel_q == SEL_STATUS);
      end
      if (cs_rise) begin
        latch_in_frame_q <= 1'b0;
      end else if (latch_now && !LINK.cs_n) begin
        latch_in_frame_q <= 1'b1;
      end
      if (cs_rise && latch_in_frame_q) begin
        coll_q <= 1'b1;
      end else if (cs_rise && status_read_q) begin
        coll_q <= 1'b0;
      end
    end
  end

  assign LINK.dout = dout_q;
  assign LINK.eoc = eoc_q;
  assign PHASE_OUT = phase_q;
  assign DEINT_INDEX_OUT = idx_q;
  assign DEINT_NEG_OUT = neg_q;
  assign INTEG_OUT = int_q;
  assign USER_BITS_OUT = user_q;
  assign RESULT_OUT = result_q;
endmodule

// ==== src/msps_host.sv ====
// host-side serial master: start command and three-transfer result read
`timescale 1ns/1ps
module msps_host #(
  parameter int SCLK_HALF_P = msps_pkg::SCLK_HALF_CLKS,
  parameter int IDLE_LIMIT_P = msps_pkg::IDLE_LIMIT_CLKS
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  msps_if.host LINK,
  input wire logic START_IN,
  input wire logic MODE50_IN,
  input wire logic HIGH_RATE_IN,
  input wire logic READ_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic [7:0] STATUS_OUT,
  output logic [18:0] RESULT_OUT,
  output logic STALE_OUT
);
  import msps_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_WAIT_EOC, H_SELECT, H_SHIFT, H_GAP} msps_hstate_t;

  msps_hstate_t st_q;
  logic [3:0] half_q;
  logic [3:0] bit_q;
  logic [1:0] xfer_q;
  logic reading_q;
  logic [7:0] cmd_q;
  logic [7:0] rx_q;
  logic cs_n_q;
  logic sclk_q;
  logic din_q;
  logic busy_q;
  logic done_q;
  logic [7:0] status_q;
  logic [18:0] result_q;
  logic stale_q;
  logic stale_next_q;
  logic [29:0] idle_q;
  logic [7:0] next_cmd;

  // read order: select low, select high, leave status selected
  always_comb begin
    next_cmd = 8'h00;
    case (xfer_q)
      2'h0: next_cmd[CMD_SEL_LOW_BIT] = 1'b0;
      2'h1: next_cmd[CMD_SEL_LOW_BIT] = 1'b1;
      default: next_cmd[CMD_SEL_HIGH_BIT] = 1'b1;
    endcase
  end

  // transfer engine, drives the link clock by a divider
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      st_q <= H_IDLE;
      half_q <= 4'h0;
      bit_q <= 4'h0;
      xfer_q <= 2'h0;
      reading_q <= 1'b0;
      cmd_q <= 8'h00;
      rx_q <= 8'h00;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      din_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          xfer_q <= 2'h0;
          if (START_IN) begin
            cmd_q <= 8'h00;
            cmd_q[CMD_START_BIT] <= 1'b1;
            cmd_q[CMD_MODE50_BIT] <= MODE50_IN || HIGH_RATE_IN;
            cmd_q[CMD_SEL_HIGH_BIT] <= 1'b1;
            reading_q <= 1'b0;
            busy_q <= 1'b1;
            st_q <= H_SELECT;
          end else if (READ_IN) begin
            reading_q <= 1'b1;
            busy_q <= 1'b1;
            st_q <= H_WAIT_EOC;
          end
        end
        H_WAIT_EOC: begin
          // no traffic while converting
          if (LINK.eoc) begin
            cmd_q <= next_cmd;
            st_q <= H_SELECT;
          end
        end
        H_SELECT: begin
          cs_n_q <= 1'b0;
          din_q <= cmd_q[7];
          bit_q <= 4'h0;
          half_q <= 4'h0;
          st_q <= H_SHIFT;
        end
        H_SHIFT: begin
          half_q <= half_q + 4'h1;
          if (half_q == 4'(SCLK_HALF_P - 1)) begin
            half_q <= 4'h0;
            sclk_q <= !sclk_q;
            if (!sclk_q) begin
              rx_q <= {rx_q[6:0], LINK.dout};
            end else begin
              cmd_q <= {cmd_q[6:0], 1'b0};
              din_q <= cmd_q[6];
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) begin
                cs_n_q <= 1'b1;
                st_q <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          half_q <= half_q + 4'h1;
          if (half_q == 4'(SCLK_HALF_P - 1)) begin
            if (reading_q && xfer_q != 2'h2) begin
              xfer_q <= xfer_q + 2'h1;
              cmd_q <= (xfer_q == 2'h0) ? 8'h08 : 8'h10;
              st_q <= H_SELECT;
            end else begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= H_IDLE;
            end
          end
        end
        default: begin
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  // unpack status, low and high bytes as they arrive
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      status_q <= 8'h00;
      result_q <= 19'h00000;
    end else if (st_q == H_GAP && half_q == 4'h0 && reading_q) begin
      case (xfer_q)
        2'h0: begin
          status_q <= rx_q;
          result_q[2:0] <= rx_q[2:0];
        end
        2'h1: result_q[10:3] <= rx_q;
        default: result_q[18:11] <= rx_q;
      endcase
    end
  end

  // mark the first result after a long idle as untrustworthy
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      idle_q <= 30'(IDLE_LIMIT_P); // power-up counts as a long idle
      stale_next_q <= 1'b1;
      stale_q <= 1'b0;
    end else begin
      if (st_q == H_IDLE && START_IN) begin
        idle_q <= 30'h00000000;
      end else if (idle_q != 30'(IDLE_LIMIT_P)) begin
        idle_q <= idle_q + 30'h00000001;
      end
      if (st_q == H_IDLE && START_IN) begin
        stale_next_q <= (idle_q == 30'(IDLE_LIMIT_P));
      end
      if (st_q == H_GAP && reading_q && xfer_q == 2'h2) begin
        stale_q <= stale_next_q;
      end
    end
  end

  assign LINK.cs_n = cs_n_q;
  assign LINK.sclk = sclk_q;
  assign LINK.din = din_q;
  assign BUSY_OUT = busy_q;
  assign DONE_OUT = done_q;
  assign STATUS_OUT = status_q;
  assign RESULT_OUT = result_q;
  assign STALE_OUT = stale_q;
endmodule

// ==== verification/msps_sva.sv ====
// concurrent checks on the sequencer phases and the serial link between the two ends
`timescale 1ns/1ps
module msps_sva #(
  parameter int CONV_DIV_P = 4
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic eoc,
  input wire logic COMP_ZERO_IN,
  input wire msps_pkg::msps_phase_t PHASE_OUT,
  input wire logic [1:0] DEINT_INDEX_OUT,
  input wire logic INTEG_OUT
);
  import msps_pkg::*;

  // slack for a crossing seen mid-tick: rest of this tick, one more tick, register delay
  localparam int STOP_MAX = 2 * CONV_DIV_P + 2;

  msps_phase_t last_q;
  logic [15:0] run_q;
  logic exit_w;

  assign exit_w = (PHASE_OUT != last_q);

  // length of the visible phase in clocks; judged only at the cycle it is left
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      last_q <= PH_ZI_HOLD;
      run_q <= 16'h0000;
    end else begin
      last_q <= PHASE_OUT;
      run_q <= exit_w ? 16'h0001 : run_q + 16'h0001;
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);

  chk_hold_exit: assert property (
    exit_w && last_q == PH_ZI_HOLD |-> PHASE_OUT == PH_ZI_PRE)
    else $error("hold left for a phase other than the start zero phase");
  chk_pre_length: assert property (
    exit_w && last_q == PH_ZI_PRE |-> PHASE_OUT == PH_INTEG &&
      (run_q == 111 * CONV_DIV_P || run_q == CONV_DIV_P))
    else $error("start zero phase has the wrong length");
  chk_integ_length: assert property (
    exit_w && last_q == PH_INTEG |-> PHASE_OUT == PH_DEINT &&
      (run_q == 545 * CONV_DIV_P || run_q == 655 * CONV_DIV_P))
    else $error("integrate phase has the wrong length");
  chk_gain_length: assert property (
    exit_w && last_q == PH_RESIDUE_GAIN |-> PHASE_OUT == PH_DEINT &&
      run_q == 8 * CONV_DIV_P)
    else $error("gain phase has the wrong length or successor");
  chk_slope_order: assert property (
    exit_w && last_q inside {PH_DEINT, PH_REST} && PHASE_OUT != PH_REST |->
      PHASE_OUT == (($past(DEINT_INDEX_OUT) == LAST_DEINT) ? PH_ZI_END : PH_RESIDUE_GAIN))
    else $error("slope phase followed by the wrong phase");
  chk_end_length: assert property (
    exit_w && last_q == PH_ZI_END |-> PHASE_OUT == PH_ZI_HOLD && run_q == 20 * CONV_DIV_P)
    else $error("end zero phase has the wrong length or successor");
  chk_cross_stop: assert property (
    PHASE_OUT == PH_DEINT && COMP_ZERO_IN |-> ##[1:STOP_MAX] PHASE_OUT != PH_DEINT)
    else $error("deintegrate did not stop after the crossing");
  chk_integ_flag: assert property (
    INTEG_OUT == (PHASE_OUT == PH_INTEG))
    else $error("integrate flag disagrees with the phase");
  chk_hold_done: assert property (
    PHASE_OUT == PH_ZI_HOLD && last_q == PH_ZI_HOLD |-> eoc)
    else $error("done flag low while holding");
  chk_done_fall: assert property (
    $fell(eoc) |-> PHASE_OUT inside {PH_ZI_PRE, PH_INTEG})
    else $error("done flag fell outside the conversion start");
  chk_link_idle: assert property (
    cs_n |-> !sclk)
    else $error("link clock high outside a frame");
  chk_link_quiet: assert property (
    !eoc |-> cs_n)
    else $error("frame opened while a conversion runs");

  // main scenarios seen at least once
  cover property (exit_w && last_q == PH_ZI_PRE && run_q == CONV_DIV_P);
  cover property (exit_w && last_q == PH_ZI_PRE && run_q == 111 * CONV_DIV_P);
  cover property (exit_w && last_q == PH_RESIDUE_GAIN);
  cover property ($rose(cs_n));
endmodule

// ==== verification/testbench.sv ====
// self-checking bench joining the sequencer and its host over the serial link
`timescale 1ns/1ps
module testbench;
  import msps_pkg::*;

  // short tick keeps a conversion near 8k clocks
  localparam int DIV = 4;

  logic clk, rst, start, mode50, high_rate, read_req, comp_zero, comp_pos;
  msps_phase_t phase;
  logic [1:0] deint_idx;
  logic deint_neg, integ, busy, done, stale;
  logic [3:0] user_bits;
  logic [18:0] dev_result, host_result;
  logic [7:0] status;
  int n_errors, n_checks, dcnt, pre_cnt, integ_cnt;
  int base[4];
  int tgt[4];

  msps_if link();

  msps_device #(.CONV_DIV_P(DIV)) msps_device_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .LINK(link), .COMP_ZERO_IN(comp_zero),
    .COMP_POS_IN(comp_pos), .PHASE_OUT(phase), .DEINT_INDEX_OUT(deint_idx),
    .DEINT_NEG_OUT(deint_neg), .INTEG_OUT(integ), .USER_BITS_OUT(user_bits),
    .RESULT_OUT(dev_result));

  // idle limit above one start-to-start period, so back-to-back runs stay fresh
  msps_host #(.SCLK_HALF_P(4), .IDLE_LIMIT_P(10000)) msps_host_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .LINK(link), .START_IN(start), .MODE50_IN(mode50),
    .HIGH_RATE_IN(high_rate), .READ_IN(read_req), .BUSY_OUT(busy), .DONE_OUT(done),
    .STATUS_OUT(status), .RESULT_OUT(host_result), .STALE_OUT(stale));

  msps_sva #(.CONV_DIV_P(DIV)) msps_sva_i (
    .SYS_CLK_IN(clk), .RST_IN(rst), .cs_n(link.cs_n), .sclk(link.sclk), .eoc(link.eoc),
    .COMP_ZERO_IN(comp_zero), .PHASE_OUT(phase), .DEINT_INDEX_OUT(deint_idx),
    .INTEG_OUT(integ));

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // comparator model: crossing comes mid-tick so the stop tick is always the next one
  always @(negedge clk) begin
    if (phase == PH_DEINT) dcnt = dcnt + 1;
    else dcnt = 0;
    comp_zero <= (phase == PH_DEINT) && (dcnt > tgt[deint_idx] * DIV + 1);
    if (phase == PH_ZI_PRE) pre_cnt = pre_cnt + 1;
    if (integ === 1'b1) integ_cnt = integ_cnt + 1;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [18:0] exp, input logic [18:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // which 0: host done pulse, 1: conversion under way
  task automatic wait_until(input int which);
    int k;
    k = 0;
    while (!(which == 0 ? done === 1'b1 : link.eoc === 1'b0)) begin
      @(negedge clk);
      k++;
      if (k > 20000) begin
        n_errors++;
        $display("wrong value wait %0d expected event seen timeout", which);
        close_out();
      end
    end
  endtask

  task automatic host_op(input logic is_start);
    @(negedge clk);
    start = is_start;
    read_req = !is_start;
    @(negedge clk);
    start = 1'b0;
    read_req = 1'b0;
    wait_until(0);
  endtask

  // weighted count difference for extra deintegrate ticks
  function automatic logic [18:0] exp_diff(input logic pos, input int add[4]);
    logic [18:0] acc;
    acc = 19'h00000;
    for (int i = 0; i < 4; i++) acc = acc + 19'(add[i] * (512 >> (3 * i)));
    return pos ? acc : -acc;
  endfunction

  task automatic convert(input logic m50, input logic hr, input logic pos, input int add[4],
                         output logic [18:0] res);
    @(negedge clk);
    mode50 = m50;
    high_rate = hr;
    comp_pos = pos;
    for (int i = 0; i < 4; i++) tgt[i] = base[i] + add[i];
    pre_cnt = 0;
    integ_cnt = 0;
    host_op(1'b1);
    wait_until(1);
    host_op(1'b0);
    check("start zero length", 19'((m50 | hr) ? DIV : 111 * DIV), 19'(pre_cnt));
    check("integrate length", 19'((m50 | hr) ? 655 * DIV : 545 * DIV), 19'(integ_cnt));
    check("host result", dev_result, host_result);
    check("status done bit", 19'h00001, 19'(status[ST_EOC_BIT]));
    check("status collision", 19'h00000, 19'(status[ST_COLL_BIT]));
    check("status low bits", 19'(dev_result[2:0]), 19'(status[2:0]));
    check("status integrate bit", 19'h00000, 19'(status[ST_INT_BIT]));
    check("count down flag", 19'(!pos), 19'(deint_neg));
    check("busy after read", 19'h00000, 19'(busy));
    check("phase after end", 19'(PH_ZI_HOLD), 19'(phase));
    res = host_result;
    $display("test conversion mode50 %0d high rate %0d done", m50, hr);
  endtask

  initial begin
    logic [18:0] r0, r1, r2;
    logic pos;
    int add0[4];
    int add1[4];
    n_errors = 0;
    n_checks = 0;
    rst = 1'b1;
    start = 1'b0;
    mode50 = 1'b0;
    high_rate = 1'b0;
    read_req = 1'b0;
    comp_zero = 1'b0;
    comp_pos = 1'b0;
    dcnt = 0;
    pre_cnt = 0;
    integ_cnt = 0;
    void'($urandom(48538));
    for (int i = 0; i < 4; i++) begin
      base[i] = 2 + $urandom % 28;
      tgt[i] = base[i];
      add0[i] = 0;
      add1[i] = 1 + $urandom % 5;
    end
    pos = 1'($urandom % 2);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    // idle after reset: no start, so it must keep holding
    repeat (40) @(negedge clk);
    check("phase idle", 19'(PH_ZI_HOLD), 19'(phase));
    check("done idle", 19'h00001, 19'(link.eoc));
    check("user bits", 19'h00000, 19'(user_bits));
    $display("test reset hold done");
    // one read per conversion, no extra zero reading between them
    convert(1'b0, 1'b0, pos, add0, r0);
    check("stale first", 19'h00001, 19'(stale));
    convert(1'b1, 1'b0, pos, add1, r1);
    check("stale back to back", 19'h00000, 19'(stale));
    check("weighted difference", exp_diff(pos, add1), r1 - r0);
    // long idle, then forced 50Hz with the opposite polarity
    repeat (3000) @(negedge clk);
    convert(1'b0, 1'b1, !pos, add0, r2);
    check("stale after idle", 19'h00001, 19'(stale));
    check("polarity mirror", -r0, r2);
    close_out();
  end
endmodule
